// ===== verilog/kplk_pkg.sv
// constants, types and helpers shared by the keypad lock and event block
package kplk_pkg;
	// ==========================================
	// event code space
	localparam int KPLK_NPIN = 18;
	localparam logic [6:0] KPLK_NCOLS = 7'h0A;
	localparam logic [6:0] KPLK_KEY_BASE = 7'h01;
	localparam logic [6:0] KPLK_KEY_LAST = 7'h50;
	localparam logic [6:0] KPLK_PIN_BASE = 7'h61;
	localparam logic [6:0] KPLK_PIN_LAST = 7'h72;
	localparam int KPLK_PRESS_BIT = 7;
	// ==========================================
	// register byte offsets
	localparam logic [7:0] KPLK_OFS_CTRL = 8'h00;
	localparam logic [7:0] KPLK_OFS_UNLOCK_KEYS = 8'h04;
	localparam logic [7:0] KPLK_OFS_TIMERS = 8'h08;
	localparam logic [7:0] KPLK_OFS_PIN_EN = 8'h0C;
	localparam logic [7:0] KPLK_OFS_PIN_POL = 8'h10;
	localparam logic [7:0] KPLK_OFS_STATUS = 8'h14;
	// ==========================================
	// field positions
	localparam int KPLK_CTRL_LOCK = 0;
	localparam int KPLK_CTRL_UT_EN = 1;
	localparam int KPLK_CTRL_MT_EN = 2;
	localparam int KPLK_CTRL_TRK_DIS = 3;
	localparam int KPLK_KEY2_POS = 8;
	localparam int KPLK_MASK_POS = 8;
	localparam int KPLK_CNT_POS = 8;
	localparam int KPLK_LAST_POS = 16;
	// ==========================================
	// reset values
	localparam logic [3:0] KPLK_CTRL_RST = 4'h0;
	localparam logic [14:0] KPLK_KEYS_RST = 15'h0000;
	localparam logic [15:0] KPLK_TIMERS_RST = 16'h0000;
	localparam logic [17:0] KPLK_PIN_RST = 18'h00000;
	// ==========================================
	// timer base: one tick per millisecond
	localparam int KPLK_TICK_US = 1000;
	localparam int KPLK_CLK_MHZ = 25;
	localparam int KPLK_TICK_CYCLES = KPLK_TICK_US * KPLK_CLK_MHZ;
	// ==========================================
	// lock state machine, gray coded along unlocked-locked-first
	typedef enum logic [1:0] {
		KPLK_ST_UNLOCKED = 2'h0,
		KPLK_ST_LOCKED = 2'h1,
		KPLK_ST_FIRST = 2'h3
	} kplk_state_type;
	// matrix key code from row and column
	function automatic logic [6:0] kplk_key_code(input logic [2:0] row, input logic [3:0] col);
		kplk_key_code = 7'({4'h0, row} * KPLK_NCOLS + {3'h0, col} + KPLK_KEY_BASE);
	endfunction : kplk_key_code
endpackage : kplk_pkg

// ===== verilog/kplk_core.sv
// keypad lock, unlock sequence and input-pin event logic with wishbone registers
`timescale 1ns/1ps
module kplk_core import kplk_pkg::*; #(
	parameter int TICK_CYCLES = KPLK_TICK_CYCLES,
	parameter int NPIN = KPLK_NPIN
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// wishbone slave
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_we_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// debounced matrix key events from the scan engine
	input wire logic key_valid,
	input wire logic [2:0] key_row,
	input wire logic [3:0] key_col,
	input wire logic key_press,
	// general input pins, asynchronous
	input wire logic [NPIN-1:0] general_input_pin,
	// event output, interrupt pulses and unlock status level
	output logic evt_valid,
	output logic [7:0] evt_byte,
	output logic key_int,
	output logic keylock_int,
	output logic unlocked
);
	// ==========================================
	// helpers
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		for (int i = 0; i < 4; i++) begin
			merge[i*8 +: 8] = sel[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
		end
	endfunction : merge

	// ==========================================
	// register and bus state
	logic [3:0] ctrl_q, ctrl_d;
	logic [14:0] keys_q, keys_d;
	logic [15:0] tmr_q, tmr_d;
	logic [NPIN-1:0] pen_q, pen_d, ppol_q, ppol_d;
	logic ack_q, ack_d;
	logic [31:0] rdat_q, rdat_d;
	logic [31:0] wm;
	logic lock_set;
	// core state
	kplk_state_type st_q, st_d;
	logic [NPIN-1:0] sync1_q, sync2_q, pressed_q, pressed_d;
	logic [15:0] tick_q, tick_d;
	logic [7:0] mcnt_q, mcnt_d, ucnt_q, ucnt_d, ecnt_q, ecnt_d;
	logic mrun_q, mrun_d;
	logic ev_q, ev_d, kint_q, kint_d, klint_q, klint_d;
	logic [7:0] byte_q, byte_d;
	// combinational event selection
	logic have, is_pin, press, locked, record, tick, m_exp, u_exp;
	logic [6:0] code;
	logic [NPIN-1:0] hit;

	assign locked = (st_q != KPLK_ST_UNLOCKED);

	// ==========================================
	// wishbone: ack one cycle after request, write at the acked edge
	always_comb begin
		ctrl_d = ctrl_q;
		keys_d = keys_q;
		tmr_d = tmr_q;
		pen_d = pen_q;
		ppol_d = ppol_q;
		rdat_d = rdat_q;
		lock_set = 1'b0;
		wm = 32'h00000000;
		ack_d = wb_cyc_i && wb_stb_i && !ack_q;
		if (ack_d) begin
			case (wb_adr_i)
				KPLK_OFS_CTRL: rdat_d = {28'h0000000, ctrl_q};
				KPLK_OFS_UNLOCK_KEYS: rdat_d = {17'h00000, keys_q};
				KPLK_OFS_TIMERS: rdat_d = {16'h0000, tmr_q};
				KPLK_OFS_PIN_EN: rdat_d = 32'(pen_q);
				KPLK_OFS_PIN_POL: rdat_d = 32'(ppol_q);
				KPLK_OFS_STATUS: rdat_d = {8'h00, byte_q, ecnt_q, 5'h00, st_q, !locked};
				default: rdat_d = 32'h00000000;
			endcase
		end
		if (wb_cyc_i && wb_stb_i && wb_we_i && ack_q) begin
			case (wb_adr_i)
				KPLK_OFS_CTRL: begin
					wm = merge({28'h0000000, ctrl_q}, wb_dat_i, wb_sel_i);
					ctrl_d = wm[3:0];
					ctrl_d[KPLK_CTRL_LOCK] = 1'b0;
					lock_set = wb_sel_i[0] && wb_dat_i[KPLK_CTRL_LOCK];
				end
				KPLK_OFS_UNLOCK_KEYS: begin
					wm = merge({17'h00000, keys_q}, wb_dat_i, wb_sel_i);
					keys_d = wm[14:0];
				end
				KPLK_OFS_TIMERS: begin
					wm = merge({16'h0000, tmr_q}, wb_dat_i, wb_sel_i);
					tmr_d = wm[15:0];
				end
				KPLK_OFS_PIN_EN: begin
					wm = merge(32'(pen_q), wb_dat_i, wb_sel_i);
					pen_d = wm[NPIN-1:0];
				end
				KPLK_OFS_PIN_POL: begin
					wm = merge(32'(ppol_q), wb_dat_i, wb_sel_i);
					ppol_d = wm[NPIN-1:0];
				end
				default: ;
			endcase
		end
	end

	// register file flops, all defaults at reset
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_q <= KPLK_CTRL_RST;
			keys_q <= KPLK_KEYS_RST;
			tmr_q <= KPLK_TIMERS_RST;
			pen_q <= KPLK_PIN_RST;
			ppol_q <= KPLK_PIN_RST;
			ack_q <= 1'b0;
			rdat_q <= 32'h00000000;
		end else begin
			ctrl_q <= ctrl_d;
			keys_q <= keys_d;
			tmr_q <= tmr_d;
			pen_q <= pen_d;
			ppol_q <= ppol_d;
			ack_q <= ack_d;
			rdat_q <= rdat_d;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;

	// ==========================================
	// core: pin levels, event choice, lock machine and timers
	always_comb begin
		have = 1'b0;
		is_pin = 1'b0;
		press = 1'b0;
		code = 7'h00;
		pressed_d = pressed_q & pen_q;
		// pin wants service while its active level differs from the armed state
		hit = pen_q & ((sync2_q ~^ ppol_q) ^ pressed_q);
		if (key_valid) begin
			have = 1'b1;
			press = key_press;
			code = kplk_key_code(key_row, key_col);
		end else begin
			for (int i = NPIN - 1; i >= 0; i--) begin
				if (hit[i]) begin
					have = 1'b1;
					is_pin = 1'b1;
					press = !pressed_q[i];
					code = KPLK_PIN_BASE + 7'(i);
				end
			end
			for (int i = 0; i < NPIN; i++) begin
				if (hit[i] && (hit & ((NPIN'(1) << i) - NPIN'(1))) == '0) begin
					pressed_d[i] = !pressed_q[i];
				end
			end
		end
		// matrix and pin events share one path
		record = have && (!locked || (is_pin && !ctrl_q[KPLK_CTRL_TRK_DIS]));
		ev_d = record;
		byte_d = record ? {press, code} : byte_q;
		ecnt_d = ecnt_q + 8'(record);
		kint_d = record || (locked && have && press);
		klint_d = 1'b0;
		// timer tick
		tick = (tick_q == 16'(TICK_CYCLES - 1));
		tick_d = tick ? 16'h0000 : tick_q + 16'h0001;
		m_exp = ctrl_q[KPLK_CTRL_MT_EN] && mrun_q && tick && mcnt_q >= tmr_q[15:KPLK_MASK_POS];
		u_exp = ctrl_q[KPLK_CTRL_MT_EN] && ctrl_q[KPLK_CTRL_UT_EN] && st_q == KPLK_ST_FIRST
			&& tick && ucnt_q >= tmr_q[7:0];
		mcnt_d = (mrun_q && tick) ? mcnt_q + 8'h01 : mcnt_q;
		ucnt_d = (st_q == KPLK_ST_FIRST && tick) ? ucnt_q + 8'h01 : ucnt_q;
		mrun_d = mrun_q;
		st_d = st_q;
		case (st_q)
			KPLK_ST_UNLOCKED: begin
				mrun_d = 1'b0;
			end
			KPLK_ST_LOCKED: begin
				if (m_exp) begin
					mrun_d = 1'b0;
				end else if (have && press) begin
					if (!mrun_q) begin
						mrun_d = 1'b1;
						mcnt_d = 8'h00;
					end
					if (code == keys_q[6:0]) begin
						st_d = KPLK_ST_FIRST;
						ucnt_d = 8'h00;
					end
				end
			end
			KPLK_ST_FIRST: begin
				if (m_exp || u_exp) begin
					st_d = KPLK_ST_LOCKED;
					mrun_d = 1'b0;
				end else if (have && press) begin
					if (code == keys_q[14:KPLK_KEY2_POS]) begin
						st_d = KPLK_ST_UNLOCKED;
						klint_d = 1'b1;
					end else if (code != keys_q[6:0]) begin
						st_d = KPLK_ST_LOCKED;
					end
				end
			end
			default: st_d = KPLK_ST_UNLOCKED;
		endcase
		if (lock_set && st_q == KPLK_ST_UNLOCKED) begin
			st_d = KPLK_ST_LOCKED;
		end
	end

	// core flops
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sync1_q <= '0;
			sync2_q <= '0;
			pressed_q <= '0;
			st_q <= KPLK_ST_UNLOCKED;
			tick_q <= 16'h0000;
			mcnt_q <= 8'h00;
			ucnt_q <= 8'h00;
			ecnt_q <= 8'h00;
			mrun_q <= 1'b0;
			ev_q <= 1'b0;
			kint_q <= 1'b0;
			klint_q <= 1'b0;
			byte_q <= 8'h00;
		end else begin
			sync1_q <= general_input_pin;
			sync2_q <= sync1_q;
			pressed_q <= pressed_d;
			st_q <= st_d;
			tick_q <= tick_d;
			mcnt_q <= mcnt_d;
			ucnt_q <= ucnt_d;
			ecnt_q <= ecnt_d;
			mrun_q <= mrun_d;
			ev_q <= ev_d;
			kint_q <= kint_d;
			klint_q <= klint_d;
			byte_q <= byte_d;
		end
	end

	assign evt_valid = ev_q;
	assign evt_byte = byte_q;
	assign key_int = kint_q;
	assign keylock_int = klint_q;
	assign unlocked = !locked;

	// ==========================================
	// assertions
	property p_code;
		@(posedge clk) disable iff (rst) key_valid && !locked
			|=> evt_valid && evt_byte == {$past(key_press), kplk_key_code($past(key_row), $past(key_col))};
	endproperty
	a_code: assert property (p_code) else $error("key code wrong");
	property p_lock_quiet;
		@(posedge clk) disable iff (rst) key_valid && locked |=> !evt_valid;
	endproperty
	a_lock_quiet: assert property (p_lock_quiet) else $error("key recorded while locked");
	property p_wake;
		@(posedge clk) disable iff (rst) have && press && locked |=> key_int;
	endproperty
	a_wake: assert property (p_wake) else $error("no wake interrupt");
	property p_klint;
		@(posedge clk) disable iff (rst) keylock_int
			|-> $past(st_q) == KPLK_ST_FIRST && st_q == KPLK_ST_UNLOCKED;
	endproperty
	a_klint: assert property (p_klint) else $error("keylock without sequence");
	property p_mexp;
		@(posedge clk) disable iff (rst) m_exp |=> st_q == KPLK_ST_LOCKED && !mrun_q;
	endproperty
	a_mexp: assert property (p_mexp) else $error("mask expiry ignored");
	property p_uexp;
		@(posedge clk) disable iff (rst) st_q == KPLK_ST_FIRST && !ctrl_q[KPLK_CTRL_MT_EN] && !have
			|=> st_q == KPLK_ST_FIRST;
	endproperty
	a_uexp: assert property (p_uexp) else $error("unlock timeout without mask");
	property p_range;
		@(posedge clk) disable iff (rst) evt_valid |-> (evt_byte[6:0] >= KPLK_KEY_BASE
			&& evt_byte[6:0] <= KPLK_KEY_LAST) || (evt_byte[6:0] >= KPLK_PIN_BASE
			&& evt_byte[6:0] <= KPLK_PIN_LAST);
	endproperty
	a_range: assert property (p_range) else $error("event code out of range");
	property p_track;
		@(posedge clk) disable iff (rst) locked && ctrl_q[KPLK_CTRL_TRK_DIS] |=> !evt_valid;
	endproperty
	a_track: assert property (p_track) else $error("pin event while locked");
	property p_pin_rel;
		@(posedge clk) disable iff (rst) is_pin && !press && record
			|=> evt_valid && !evt_byte[KPLK_PRESS_BIT];
	endproperty
	a_pin_rel: assert property (p_pin_rel) else $error("release marked as press");
	c_unlock: cover property (@(posedge clk) disable iff (rst) keylock_int);
	c_mexp: cover property (@(posedge clk) disable iff (rst) m_exp);
	c_pin: cover property (@(posedge clk) disable iff (rst) evt_valid && evt_byte[6:0] >= KPLK_PIN_BASE);
endmodule : kplk_core

// ===== testbench/kplk_keysrc.sv
// scan engine model that hands debounced key events to the core
`timescale 1ns/1ps
module kplk_keysrc (
	// clock
	input wire logic clk,
	// event lines
	output logic key_valid,
	output logic [2:0] key_row,
	output logic [3:0] key_col,
	output logic key_press
);
	// ==========================================
	// idle lines
	initial begin
		key_valid = 1'b0;
		key_row = 3'h0;
		key_col = 4'h0;
		key_press = 1'b0;
	end
	// one pulse; lines scrambled afterwards so nothing lingers
	task automatic send(input logic [2:0] r, input logic [3:0] c, input logic p);
		@(posedge clk);
		key_valid <= 1'b1;
		key_row <= r;
		key_col <= c;
		key_press <= p;
		@(posedge clk);
		key_valid <= 1'b0;
		key_row <= ~r;
		key_col <= ~c;
		key_press <= ~p;
	endtask : send
endmodule : kplk_keysrc

// ===== testbench/kplk_core_test.sv
// self-checking bench for the keypad lock and input event block
`timescale 1ns/1ps
module kplk_core_test import kplk_pkg::*;;
	// ==========================================
	// stimulus and observed signals
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic we = 1'b0;
	logic cyc = 1'b0;
	logic [17:0] pin = 18'h00006;
	logic [31:0] rdat, rd;
	logic ack, kv, kp, evt_valid, key_int, keylock_int, unlocked;
	logic [2:0] kr;
	logic [3:0] kc;
	logic [7:0] evt_byte;
	int err_count = 0;
	int samples_checked = 0;
	int n_evt = 0, n_ki = 0, n_kl = 0, e0, k0, l0;
	int codes[3] = '{1, 36, 80};
	kplk_core #(.TICK_CYCLES(4)) kplk_core_i (.clk(clk), .rst(rst), .wb_adr_i(adr),
		.wb_dat_i(wdat), .wb_sel_i(4'hF), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(cyc),
		.wb_dat_o(rdat), .wb_ack_o(ack), .key_valid(kv), .key_row(kr), .key_col(kc),
		.key_press(kp), .general_input_pin(pin), .evt_valid(evt_valid),
		.evt_byte(evt_byte), .key_int(key_int), .keylock_int(keylock_int),
		.unlocked(unlocked));
	kplk_keysrc kplk_keysrc_i (.clk(clk), .key_valid(kv), .key_row(kr), .key_col(kc),
		.key_press(kp));
	always #20 clk = ~clk;
	// pulse counters
	always @(posedge clk) begin
		if (evt_valid === 1'b1) n_evt++;
		if (key_int === 1'b1) n_ki++;
		if (keylock_int === 1'b1) n_kl++;
	end
	// ==========================================
	// helpers
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		@(posedge clk);
		while (ack !== 1'b1 && n < 50) begin
			@(posedge clk);
			n++;
		end
		if (n >= 50) err_count++;
		rd = rdat;
		cyc <= 1'b0;
		we <= 1'b0;
		@(posedge clk);
	endtask : wb
	task automatic settle();
		repeat (6) @(posedge clk);
	endtask : settle
	task automatic snap();
		e0 = n_evt;
		k0 = n_ki;
		l0 = n_kl;
	endtask : snap
	task automatic key(input int code, input logic p);
		kplk_keysrc_i.send(3'((code - 1) / 10), 4'((code - 1) % 10), p);
		settle();
	endtask : key
	task automatic pins(input logic [17:0] v);
		@(posedge clk);
		pin <= v;
		settle();
	endtask : pins
	task automatic close_out();
		$display("compares %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : close_out
	// ==========================================
	// tests
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		wb(1'b0, KPLK_OFS_CTRL, 32'h0);
		chk(rd, 32'h0);
		wb(1'b0, KPLK_OFS_STATUS, 32'h0);
		chk(rd, 32'h1);
		wb(1'b0, 8'h20, 32'h0);
		chk(rd, 32'h0);
		$display("reset test done");
		foreach (codes[i]) begin
			snap();
			key(codes[i], 1'b1);
			chk(evt_byte, {24'h0, 1'b1, 7'(codes[i])});
			key(codes[i], 1'b0);
			chk(evt_byte, {24'h0, 1'b0, 7'(codes[i])});
			chk(n_evt - e0, 2);
		end
		$display("code test done");
		wb(1'b1, KPLK_OFS_UNLOCK_KEYS, 32'h0000610C);
		wb(1'b1, KPLK_OFS_PIN_POL, 32'h1);
		wb(1'b1, KPLK_OFS_PIN_EN, 32'h7);
		snap();
		pins(18'h00004);
		chk(evt_byte, 32'hE2);
		pins(18'h00006);
		chk(evt_byte, 32'h62);
		pins(18'h00007);
		chk(evt_byte, 32'hE1);
		pins(18'h00006);
		chk(evt_byte, 32'h61);
		chk(n_ki - k0, 4);
		$display("pin test done");
		wb(1'b1, KPLK_OFS_CTRL, 32'h1);
		wb(1'b0, KPLK_OFS_STATUS, 32'h0);
		chk(rd[2:0], 32'h2);
		snap();
		key(5, 1'b1);
		chk(n_ki - k0, 1);
		chk(n_evt - e0, 0);
		key(12, 1'b1);
		wb(1'b0, KPLK_OFS_STATUS, 32'h0);
		chk(rd[2:0], 32'h6);
		key(5, 1'b1);
		wb(1'b0, KPLK_OFS_STATUS, 32'h0);
		chk(rd[2:0], 32'h2);
		key(12, 1'b1);
		pins(18'h00007);
		chk(unlocked, 32'h1);
		chk(n_kl - l0, 1);
		chk(evt_byte, 32'hE1);
		chk(n_evt - e0, 1);
		pins(18'h00006);
		chk(evt_byte, 32'h61);
		$display("lock test done");
		wb(1'b1, KPLK_OFS_TIMERS, 32'h00000802);
		wb(1'b1, KPLK_OFS_CTRL, 32'h5);
		key(12, 1'b1);
		repeat (80) @(posedge clk);
		pins(18'h00007);
		chk(unlocked, 32'h0);
		pins(18'h00006);
		key(12, 1'b1);
		pins(18'h00007);
		chk(unlocked, 32'h1);
		pins(18'h00006);
		wb(1'b1, KPLK_OFS_CTRL, 32'h3);
		key(12, 1'b1);
		repeat (80) @(posedge clk);
		pins(18'h00007);
		chk(unlocked, 32'h1);
		pins(18'h00006);
		wb(1'b1, KPLK_OFS_CTRL, 32'h7);
		key(12, 1'b1);
		repeat (40) @(posedge clk);
		pins(18'h00007);
		chk(unlocked, 32'h0);
		pins(18'h00006);
		$display("timer test done");
		wb(1'b1, KPLK_OFS_CTRL, 32'h9);
		snap();
		pins(18'h00002);
		pins(18'h00006);
		chk(n_evt - e0, 0);
		wb(1'b1, KPLK_OFS_CTRL, 32'h0);
		snap();
		pins(18'h00002);
		chk(evt_byte, 32'hE3);
		pins(18'h00006);
		chk(n_evt - e0, 2);
		$display("tracking test done");
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		wb(1'b0, KPLK_OFS_TIMERS, 32'h0);
		chk(rd, 32'h0);
		wb(1'b0, KPLK_OFS_STATUS, 32'h0);
		chk(rd, 32'h1);
		$display("second reset test done");
		close_out();
	end
	// watchdog against a hung handshake
	initial begin
		#(40 * 8000);
		err_count++;
		close_out();
	end
endmodule : kplk_core_test
